// file: src/dts_pkg.sv
// Package for the dual timer start, match and interrupt block.
// Assumes one 100 MHz clock and a plain strobed register port.
package dts_pkg;
    // Register port and counter widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    // Register offsets (register index on the plain port)
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_IRQ_REQ = 4'h1;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h2;
    localparam logic [3:0] OFS_START = 4'h3;
    localparam logic [3:0] OFS_GRA0 = 4'h4;
    localparam logic [3:0] OFS_GRA1 = 4'h5;
    localparam logic [3:0] OFS_CNT0 = 4'h6;
    localparam logic [3:0] OFS_CNT1 = 4'h7;
    localparam logic [3:0] OFS_EVT_STATUS = 4'h8;
    localparam logic [3:0] OFS_EVT_CLEAR = 4'h9;
    localparam logic [3:0] OFS_EVT_ENABLE = 4'ha;
    // Field positions
    localparam int POS_MATCH_A = 0;
    localparam int POS_CH0_IRQ = 1;
    localparam int POS_CH0_RUN = 0;
    localparam int POS_CH1_RUN = 1;
    localparam int POS_CH0_CONT = 2;
    localparam int POS_CH1_CONT = 3;
    localparam int POS_EVT_CH0 = 0;
    localparam int POS_EVT_CH1 = 1;
    // Reset values
    localparam logic RST_IRQ_MASK = 1'h1;
    localparam logic [3:0] RST_START = 4'h0;
    localparam logic [15:0] RST_GRA = 16'hffff;
    localparam logic [15:0] RST_CNT = 16'h0000;

    // Register port request from software
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dts_bus_type;

    // Whole state of the block
    typedef struct packed {
        logic match_flag_a;
        logic clear_armed;
        logic ch0_irq_request;
        logic ch0_irq_mask;
        logic [3:0] start;
        logic [15:0] gra0;
        logic [15:0] gra1;
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        logic [1:0] evt_status;
        logic [1:0] evt_enable;
        logic [15:0] rdata;
        logic irq;
        logic ch0_int;
    } dts_state_type;
endpackage : dts_pkg

// file: src/dts_timer.sv
// Two timer channels with start control, match flag A and interrupts.
// Assumes software drives the plain strobed port synchronous to sys_clk_i.
// Counters step once per clock and wrap at ffff when set to continue.
//
// What this block does
// - Set match flag A, status bit 0, when counter 0 equals register A while channel 0 runs.
// - Flag A clears only by reading status, then writing 0 to bit 0.
// - Channel 0 request flag, bit 1, reads 1 while a request is pending.
// - Channel 0 mask bit 1: 0 enables the interrupt, 1 disables it.
// - Start bit 3: channel 1 stops at its match when 0, continues when 1.
// - Start bit 2: channel 0 stops at its match when 0, continues when 1.
// - Start bit 1 halts channel 1 when 0 and runs it when 1.
// - Start bit 0 halts channel 0 when 0 and runs it when 1.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dts_timer
    import dts_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire dts_bus_type bus_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic irq_o,
    output logic ch0_int_o
);

    dts_state_type st_r;
    dts_state_type st_nxt;
    logic match0;
    logic match1;

    // Write strobe aimed at one register
    function automatic logic wr_hit(input dts_bus_type b,
                                    input logic [3:0] ofs);
        wr_hit = b.wr && (b.addr == ofs);
    endfunction : wr_hit

    // Read strobe aimed at one register
    function automatic logic rd_hit(input dts_bus_type b,
                                    input logic [3:0] ofs);
        rd_hit = b.rd && (b.addr == ofs);
    endfunction : rd_hit

    // Match only counts while the channel runs, so a stopped counter
    // parked on register A does not keep firing
    assign match0 = st_r.start[POS_CH0_RUN] && (st_r.cnt0 == st_r.gra0);
    assign match1 = st_r.start[POS_CH1_RUN] && (st_r.cnt1 == st_r.gra1);

    // Next state of every register
    always_comb
    begin
        st_nxt = st_r;

        // Software writes to plain control registers
        if (wr_hit(bus_i, OFS_IRQ_REQ))
        begin
            st_nxt.ch0_irq_request = bus_i.wdata[POS_CH0_IRQ];
        end
        if (wr_hit(bus_i, OFS_IRQ_MASK))
        begin
            st_nxt.ch0_irq_mask = bus_i.wdata[POS_CH0_IRQ];
        end
        if (wr_hit(bus_i, OFS_START))
        begin
            st_nxt.start = bus_i.wdata[3:0];
        end
        if (wr_hit(bus_i, OFS_GRA0))
        begin
            st_nxt.gra0 = bus_i.wdata;
        end
        if (wr_hit(bus_i, OFS_GRA1))
        begin
            st_nxt.gra1 = bus_i.wdata;
        end
        if (wr_hit(bus_i, OFS_EVT_ENABLE))
        begin
            st_nxt.evt_enable = bus_i.wdata[1:0];
        end
        if (wr_hit(bus_i, OFS_EVT_CLEAR))
        begin
            st_nxt.evt_status = st_r.evt_status & ~bus_i.wdata[1:0];
        end

        // Channel 0 counter: halt, run, stop or continue at match
        if (wr_hit(bus_i, OFS_CNT0))
        begin
            st_nxt.cnt0 = bus_i.wdata;
        end
        else if (st_r.start[POS_CH0_RUN])
        begin
            if (match0 && !st_r.start[POS_CH0_CONT])
            begin
                st_nxt.start[POS_CH0_RUN] = 1'b0;
            end
            else
            begin
                st_nxt.cnt0 = st_r.cnt0 + 16'h0001;
            end
        end

        // Channel 1 counter, same scheme
        if (wr_hit(bus_i, OFS_CNT1))
        begin
            st_nxt.cnt1 = bus_i.wdata;
        end
        else if (st_r.start[POS_CH1_RUN])
        begin
            if (match1 && !st_r.start[POS_CH1_CONT])
            begin
                st_nxt.start[POS_CH1_RUN] = 1'b0;
            end
            else
            begin
                st_nxt.cnt1 = st_r.cnt1 + 16'h0001;
            end
        end

        // Clear of flag A needs a prior status read that saw it set;
        // any status write uses up that read
        if (rd_hit(bus_i, OFS_STATUS) && st_r.match_flag_a)
        begin
            st_nxt.clear_armed = 1'b1;
        end
        if (wr_hit(bus_i, OFS_STATUS))
        begin
            st_nxt.clear_armed = 1'b0;
            if (st_r.clear_armed && !bus_i.wdata[POS_MATCH_A])
            begin
                st_nxt.match_flag_a = 1'b0;
            end
        end

        // Hardware sets win over same-cycle clears
        if (match0)
        begin
            st_nxt.match_flag_a = 1'b1;
            st_nxt.ch0_irq_request = 1'b1;
            st_nxt.evt_status[POS_EVT_CH0] = 1'b1;
        end
        if (match1)
        begin
            st_nxt.evt_status[POS_EVT_CH1] = 1'b1;
        end

        // Read data, valid only in the cycle after the strobe
        st_nxt.rdata = 16'h0000;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                OFS_STATUS: st_nxt.rdata[POS_MATCH_A] = st_r.match_flag_a;
                OFS_IRQ_REQ:
                    st_nxt.rdata[POS_CH0_IRQ] = st_r.ch0_irq_request;
                OFS_IRQ_MASK:
                    st_nxt.rdata[POS_CH0_IRQ] = st_r.ch0_irq_mask;
                OFS_START: st_nxt.rdata[3:0] = st_r.start;
                OFS_GRA0: st_nxt.rdata = st_r.gra0;
                OFS_GRA1: st_nxt.rdata = st_r.gra1;
                OFS_CNT0: st_nxt.rdata = st_r.cnt0;
                OFS_CNT1: st_nxt.rdata = st_r.cnt1;
                OFS_EVT_STATUS: st_nxt.rdata[1:0] = st_r.evt_status;
                OFS_EVT_ENABLE: st_nxt.rdata[1:0] = st_r.evt_enable;
                default: st_nxt.rdata = 16'h0000; // Unmapped and clear reg
            endcase
        end

        // Outputs follow the next flags so they leave a flop
        st_nxt.irq = |(st_nxt.evt_status & st_nxt.evt_enable);
        st_nxt.ch0_int = st_nxt.ch0_irq_request
                         && !st_nxt.ch0_irq_mask;
    end

    // State register with synchronous reset
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.ch0_irq_mask <= RST_IRQ_MASK;
            st_r.start <= RST_START;
            st_r.gra0 <= RST_GRA;
            st_r.gra1 <= RST_GRA;
            st_r.cnt0 <= RST_CNT;
            st_r.cnt1 <= RST_CNT;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops, no logic after them
    assign rdata_o = st_r.rdata;
    assign irq_o = st_r.irq;
    assign ch0_int_o = st_r.ch0_int;

    // Checks on the logic above
    // Counter checks skip write cycles, since a write wins there
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_flag_a_set: assert property (
        match0 |=> st_r.match_flag_a)
        else $error("match flag A not set after match");

    a_flag_a_clear: assert property (
        $fell(st_r.match_flag_a) |->
            $past(st_r.clear_armed) && $past(bus_i.wr)
            && ($past(bus_i.addr) == OFS_STATUS)
            && !$past(bus_i.wdata[POS_MATCH_A]))
        else $error("flag A cleared without read then write 0");

    a_no_blind_clear: assert property (
        (st_r.match_flag_a && !st_r.clear_armed) |=> st_r.match_flag_a)
        else $error("flag A cleared without prior status read");

    a_req_follows: assert property (
        match0 |=> st_r.ch0_irq_request
            && (ch0_int_o == !st_r.ch0_irq_mask))
        else $error("channel 0 request not raised by match");

    a_req_readback: assert property (
        rd_hit(bus_i, OFS_IRQ_REQ) |=>
            rdata_o[POS_CH0_IRQ] == $past(st_r.ch0_irq_request))
        else $error("request flag read back wrong");

    a_mask_gates: assert property (
        st_r.ch0_irq_mask |-> !ch0_int_o)
        else $error("masked channel 0 interrupt reached output");

    a_ch0_stop: assert property (
        (match0 && !st_r.start[POS_CH0_CONT] && !bus_i.wr) |=>
            !st_r.start[POS_CH0_RUN] && st_r.cnt0 == $past(st_r.cnt0))
        else $error("channel 0 did not stop at match");

    a_ch0_cont: assert property (
        (match0 && st_r.start[POS_CH0_CONT] && !bus_i.wr) |=>
            st_r.cnt0 == $past(st_r.cnt0) + 16'h0001)
        else $error("channel 0 did not continue past match");

    a_ch1_stop: assert property (
        (match1 && !st_r.start[POS_CH1_CONT] && !bus_i.wr) |=>
            !st_r.start[POS_CH1_RUN] && st_r.cnt1 == $past(st_r.cnt1))
        else $error("channel 1 did not stop at match");

    a_ch0_halt: assert property (
        (!st_r.start[POS_CH0_RUN] && !bus_i.wr) |=> $stable(st_r.cnt0))
        else $error("halted channel 0 counted");

    a_ch1_run: assert property (
        (st_r.start[POS_CH1_RUN] && !match1 && !bus_i.wr) |=>
            st_r.cnt1 == $past(st_r.cnt1) + 16'h0001)
        else $error("running channel 1 did not count");

    // Flag A protocol and the channel 0 request flag
    a_clear_armed: assert property (
        (rd_hit(bus_i, OFS_STATUS) && st_r.match_flag_a) |=> st_r.clear_armed)
        else $error("status read with flag A set did not arm clear");

    a_status_read: assert property (
        rd_hit(bus_i, OFS_STATUS) |=>
            rdata_o == {15'h0, $past(st_r.match_flag_a)})
        else $error("status read back wrong");

    a_req_sticky: assert property (
        (st_r.ch0_irq_request && !wr_hit(bus_i, OFS_IRQ_REQ))
            |=> st_r.ch0_irq_request)
        else $error("request flag dropped without a write");

    a_mask_opens: assert property (
        (st_r.ch0_irq_request && !st_r.ch0_irq_mask) |-> ch0_int_o)
        else $error("unmasked channel 0 request missing at output");

    // Remaining counter paths
    a_ch0_run: assert property (
        (st_r.start[POS_CH0_RUN] && !match0 && !bus_i.wr) |=>
            st_r.cnt0 == $past(st_r.cnt0) + 16'h0001)
        else $error("running channel 0 did not count");

    a_ch1_cont: assert property (
        (match1 && st_r.start[POS_CH1_CONT] && !bus_i.wr) |=>
            st_r.cnt1 == $past(st_r.cnt1) + 16'h0001)
        else $error("channel 1 did not continue past match");

    a_ch1_halt: assert property (
        (!st_r.start[POS_CH1_RUN] && !bus_i.wr) |=> $stable(st_r.cnt1))
        else $error("halted channel 1 counted");

    // Event status, event interrupt and the read port
    a_evt_ch0: assert property (
        match0 |=> st_r.evt_status[POS_EVT_CH0])
        else $error("channel 0 event bit not set by match");

    a_evt_irq: assert property (
        (match1 && st_r.evt_enable[POS_EVT_CH1]
            && !wr_hit(bus_i, OFS_EVT_ENABLE)) |=> irq_o)
        else $error("enabled channel 1 event did not raise interrupt");

    a_rdata_idle: assert property (
        !bus_i.rd |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read answer");

endmodule : dts_timer
`default_nettype wire

// file: testbench/dts_timer_test.sv
// Testbench for the dual timer block: register reads and writes, plus the irq_o and ch0_int_o outputs.
// Assumes the plain strobed port, rdata_o valid one cycle after a read.
`timescale 1ns/100ps
`default_nettype none
module dts_timer_test
    import dts_pkg::*;
;
    logic sys_clk_i;
    logic rst_n_i;
    dts_bus_type bus;
    logic [DATA_W-1:0] rdata_o;
    logic irq_o;
    logic ch0_int_o;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    dts_timer dts_timer_inst (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .bus_i(bus),
        .rdata_o(rdata_o),
        .irq_o(irq_o),
        .ch0_int_o(ch0_int_o)
    );

    // 100 MHz clock
    always #5 sys_clk_i = ~sys_clk_i;

    // Hang guard, far above the roughly 150 cycles the tests need
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    task summarize();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task chk(input string what, input logic [15:0] exp,
             input logic [15:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle write strobe
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk_i);
        bus.wr <= 1'b0;
    endtask : wr

    // Read and compare in the single cycle the data stands
    task rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge sys_clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk_i);
        bus.rd <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask : rchk

    // Let registered outputs follow a register write
    task settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : settle

    // Main sequence
    initial
    begin
        sys_clk_i = 1'b0;
        rst_n_i = 1'b0;
        bus = '0;
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rchk(OFS_IRQ_MASK, 16'h0002, "mask reset");
        rchk(OFS_START, 16'h0000, "start reset");
        rchk(OFS_STATUS, 16'h0000, "status reset");
        wr(4'hb, 16'hffff);
        rchk(4'hb, 16'h0000, "unmapped");
        // Channel 0 stops at its match, masked interrupt stays low
        wr(OFS_GRA0, 16'h0005);
        wr(OFS_START, 16'h0001);
        settle(12);
        rchk(OFS_CNT0, 16'h0005, "cnt0 held");
        rchk(OFS_START, 16'h0000, "start stop");
        chk("ch0_int masked", 16'h0, {15'h0, ch0_int_o});
        rchk(OFS_STATUS, 16'h0001, "flag a set");
        rchk(OFS_IRQ_REQ, 16'h0002, "ch0 request");
        wr(OFS_IRQ_MASK, 16'h0000);
        settle(2);
        chk("ch0_int open", 16'h1, {15'h0, ch0_int_o});
        // Writing 0 without a fresh read must not clear the flag
        wr(OFS_STATUS, 16'h0001);
        wr(OFS_STATUS, 16'h0000);
        rchk(OFS_STATUS, 16'h0001, "flag a kept");
        wr(OFS_STATUS, 16'h0000);
        rchk(OFS_STATUS, 16'h0000, "flag a clear");
        wr(OFS_IRQ_REQ, 16'h0000);
        settle(2);
        chk("ch0_int clear", 16'h0, {15'h0, ch0_int_o});
        rchk(OFS_IRQ_REQ, 16'h0000, "no request");
        // Channel 1 stops at its match; event interrupt set and cleared
        wr(OFS_GRA1, 16'h0003);
        wr(OFS_START, 16'h0002);
        settle(10);
        rchk(OFS_CNT1, 16'h0003, "cnt1 held");
        rchk(OFS_START, 16'h0000, "start1 stop");
        wr(OFS_EVT_STATUS, 16'h0000);
        rchk(OFS_EVT_STATUS, 16'h0003, "events");
        wr(OFS_EVT_ENABLE, 16'h0002);
        settle(2);
        chk("irq on", 16'h1, {15'h0, irq_o});
        wr(OFS_EVT_ENABLE, 16'h0000);
        settle(2);
        chk("irq off", 16'h0, {15'h0, irq_o});
        wr(OFS_EVT_ENABLE, 16'h0002);
        wr(OFS_EVT_CLEAR, 16'h0003);
        settle(2);
        chk("irq cleared", 16'h0, {15'h0, irq_o});
        rchk(OFS_EVT_CLEAR, 16'h0000, "clear reads 0");
        // Start sequence for complementary operation, both continuing
        wr(OFS_CNT0, 16'h0000);
        wr(OFS_CNT1, 16'h0000);
        wr(OFS_GRA0, 16'h0002);
        wr(OFS_GRA1, 16'h0002);
        rchk(OFS_STATUS, 16'h0000, "status idle");
        wr(OFS_STATUS, 16'h0000);
        wr(OFS_IRQ_REQ, 16'h0000);
        wr(OFS_IRQ_MASK, 16'h0000);
        wr(OFS_START, 16'h000f);
        settle(10);
        rchk(OFS_START, 16'h000f, "start kept");
        rchk(OFS_STATUS, 16'h0001, "flag a again");
        rchk(OFS_EVT_STATUS, 16'h0003, "both matched");
        chk("ch0_int run", 16'h1, {15'h0, ch0_int_o});
        // Halted counters keep a written value
        wr(OFS_START, 16'h0000);
        wr(OFS_CNT0, 16'h0100);
        wr(OFS_CNT1, 16'h0200);
        settle(5);
        rchk(OFS_CNT0, 16'h0100, "cnt0 halt");
        rchk(OFS_CNT1, 16'h0200, "cnt1 halt");
        summarize();
    end
endmodule : dts_timer_test
`default_nettype wire
